// >>> bench/tpo_stage_model.sv
// power stage and shutdown sources facing the six high-current pins
// assumes the bench asks for a trip; sources are idle high
`timescale 1ns/100ps
`default_nettype none
module tpo_stage_model (
    // clock
    input wire logic pclk,
    // from device
    input wire logic [5:0] pin_o,
    input wire logic [5:0] pin_oe,
    // from bench
    input wire logic [3:0] trip,
    // to device (shut_n) and to bench (level)
    output logic [3:0] shut_n,
    output logic [5:0] level
);
    logic [5:0] last_ff;
    initial begin
        shut_n = 4'hf;
        last_ff = 6'h0;
    end
    always @(posedge pclk) begin
        shut_n <= ~trip;
        last_ff <= level;
    end
    // released pins float: show a pattern that changes every cycle
    assign level = (pin_o & pin_oe) | (~last_ff & ~pin_oe);
endmodule
`default_nettype wire

// >>> bench/tpo_top_asserts.sv
// checker: output-disable and read-back relations at the tpo_top ports
// assumes ctrl is written as whole words over apb
`timescale 1ns/100ps
`default_nettype none
module tpo_chk #(
    parameter HAS_LEVEL_CHECK = 1
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_ff,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    // system
    input wire logic manual_resetn,
    input wire logic standby,
    input wire logic osc_stop,
    input wire logic [3:0] shutdown_inputs_n,
    // pins
    input wire logic [5:0] pin_o_ff,
    input wire logic [5:0] pin_oe_ff,
    input wire logic irq_ff
);
    logic [31:0] ctrl_ff;
    logic [3:0] prev_n_ff;
    logic [3:0] edge_sel;
    logic [3:0] fall;
    logic clash;
    // shadow of ctrl, to know which inputs are in edge mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 32'h0;
            prev_n_ff <= 4'hf;
        end else begin
            prev_n_ff <= shutdown_inputs_n;
            if (!manual_resetn) begin
                ctrl_ff <= 32'h0;
            end else if (pready_ff && pwrite && paddr == 8'h1c) begin
                ctrl_ff <= pwdata;
            end
        end
    end
    assign edge_sel = {ctrl_ff[15:14] == 2'h0, ctrl_ff[13:12] == 2'h0, ctrl_ff[11:10] == 2'h0, ctrl_ff[9:8] == 2'h0};
    assign fall = prev_n_ff & ~shutdown_inputs_n & edge_sel;
    assign clash = (HAS_LEVEL_CHECK != 0) && ctrl_ff[2] && (&pin_oe_ff) &&
        ((~pin_o_ff[0] & ~pin_o_ff[1]) | (~pin_o_ff[2] & ~pin_o_ff[4]) | (~pin_o_ff[3] & ~pin_o_ff[5]));

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    stby_hiz_a: assert property (
        standby [*5] |-> pin_oe_ff == 6'h00) else $error("pins driven in standby");
    osc_hiz_a: assert property (
        osc_stop [*5] |-> pin_oe_ff == 6'h00) else $error("pins driven with oscillator stopped");
    edge_hiz_a: assert property (
        |fall |-> ##[3:8] pin_oe_ff == 6'h00) else $error("falling shutdown input left pins driven");
    hold_hiz_a: assert property (
        |fall ##8 1'b1 |-> (pin_oe_ff == 6'h00) [*8]) else $error("pins released before clear");
    edge_irq_a: assert property (
        |(fall & ctrl_ff[19:16]) |-> ##[3:8] irq_ff) else $error("no interrupt on shutdown");
    lvl_hiz_a: assert property (
        clash |-> ##[1:4] pin_oe_ff == 6'h00) else $error("low-low outputs left driven");
    oe_group_a: assert property (
        pin_oe_ff == 6'h00 || pin_oe_ff == 6'h3f) else $error("pin enables split");
    buf_zero_a: assert property (
        pready_ff && !pwrite && (paddr == 8'h04 || paddr == 8'h08) |-> !prdata_ff[4]) else $error("buffer bit set");

    cover property (|fall);
    cover property (standby [*5]);
    cover property (pready_ff && pslverr_ff);
endmodule

bind tpo_top tpo_chk #(.HAS_LEVEL_CHECK(HAS_LEVEL_CHECK)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .manual_resetn(manual_resetn), .standby(standby),
    .osc_stop(osc_stop), .shutdown_inputs_n(shutdown_inputs_n), .pin_o_ff(pin_o_ff),
    .pin_oe_ff(pin_oe_ff), .irq_ff(irq_ff));
`default_nettype wire

// >>> bench/tpo_top_bench.sv
// self-checking bench for tpo_top
// assumes the stage model on the pins and apb with one wait state
`timescale 1ns/100ps
`default_nettype none
module tpo_top_bench;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic manual_resetn = 1'h1;
    logic standby = 1'h0;
    logic osc_stop = 1'h0;
    logic [3:0] trip = 4'h0;
    logic [3:0] shut_n;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [5:0] pin_o_ff;
    logic [5:0] pin_oe_ff;
    logic [5:0] level;
    logic [31:0] rd;
    logic err;
    logic [4:0] mode_sh [0:4];
    logic [3:0] codes [0:10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hd, 4'he, 4'hf};
    int divs [1:3] = '{8, 16, 128};
    int miscompares = 0;
    int compares = 0;
    int c;
    int n;
    logic [4:0] v;
    logic [15:0] dt;

    always #5 pclk = ~pclk;

    tpo_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .manual_resetn(manual_resetn), .standby(standby), .osc_stop(osc_stop), .shutdown_inputs_n(shut_n),
        .pin_o_ff(pin_o_ff), .pin_oe_ff(pin_oe_ff), .irq_ff(irq_ff));
    tpo_stage_model far (.pclk(pclk), .pin_o(pin_o_ff), .pin_oe(pin_oe_ff), .trip(trip), .shut_n(shut_n),
        .level(level));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready_ff !== 1'h1 && k < 20);
        if (k >= 20) miscompares++;
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(nm, e, rd);
    endtask

    function automatic logic [4:0] next_mode(input int ch, input logic [4:0] old, input logic [4:0] w);
        logic ok;
        ok = !(w[3:0] == 4'h3 && ch >= 3) && !(w[3:0] inside {[4'h4:4'h7]} && (ch == 0 || ch >= 3)) &&
            !((w[3:0] == 4'h8 || w[3:0] >= 4'hd) && ch != 3);
        return {(ch == 1 || ch == 2) ? 1'h0 : w[4], ok ? w[3:0] : old[3:0]};
    endfunction

    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        results;
    end

    initial begin
        void'($urandom(32'h19a9));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (c = 0; c < 5; c++) begin
            mode_sh[c] = 5'h0;
            rchk("mode", 8'h4 * c, 32'h0);
        end
        rchk("dead", 8'h14, 32'hffff);
        rchk("carrier", 8'h18, 32'hffff);
        repeat (40) begin
            c = $urandom % 5;
            v = {$urandom % 2, codes[$urandom % 11]};
            if (c == 4 && (v[3:0] == 4'h8 || v[3:0] >= 4'hd)) v[3:0] = 4'h2;
            apb(1'h1, 8'h4 * c, {27'h0, v});
            mode_sh[c] = next_mode(c, mode_sh[c], v);
            rchk("mode", 8'h4 * c, {27'h0, mode_sh[c]});
        end
        dt = $urandom;
        apb(1'h1, 8'h14, {16'h0, dt});
        apb(1'h1, 8'h18, {16'h0, ~dt});
        manual_resetn <= 1'h0;
        repeat (4) @(posedge pclk);
        manual_resetn <= 1'h1;
        repeat (4) @(posedge pclk);
        rchk("dead", 8'h14, {16'h0, dt});
        rchk("carrier", 8'h18, {16'h0, ~dt});
        rchk("mode", 8'h0c, 32'h0);
        apb(1'h0, 8'h3c, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped rd", 32'h0, rd);
        apb(1'h1, 8'h14, 32'h10);
        apb(1'h1, 8'h18, 32'h8);
        apb(1'h1, 8'h0c, 32'hd);
        apb(1'h1, 8'h1c, 32'hd);
        apb(1'h0, 8'h2c, 32'h0);
        check("ch3 load", 1'h1, rd[15:0] >= 16'h10 && rd[15:0] <= 16'h20);
        repeat (30) begin
            apb(1'h0, 8'h2c, 32'h0);
            check("aux range", 1'h1, rd[31:16] >= 16'h8 && rd[31:16] <= 16'h10);
        end
        apb(1'h1, 8'h1c, 32'h0);
        for (c = 0; c < 4; c++) begin
            apb(1'h1, 8'h1c, 32'h001f_0009);
            repeat (4) @(posedge pclk);
            check("oe", 6'h3f, pin_oe_ff);
            check("level", {26'h0, pin_o_ff}, {26'h0, level});
            check("pairs", 32'h7, {pin_o_ff[3] ^ pin_o_ff[5], pin_o_ff[2] ^ pin_o_ff[4], pin_o_ff[0] ^ pin_o_ff[1]});
            trip[c] <= 1'h1;
            repeat (10) @(posedge pclk);
            check("oe", 6'h00, pin_oe_ff);
            check("irq", 1'h1, irq_ff);
            trip[c] <= 1'h0;
            repeat (12) @(posedge pclk);
            check("oe", 6'h00, pin_oe_ff);
            rchk("status", 8'h20, 32'h1 << c);
            apb(1'h1, 8'h20, 32'h1 << c);
            repeat (3) @(posedge pclk);
            check("oe", 6'h3f, pin_oe_ff);
            check("irq", 1'h0, irq_ff);
        end
        apb(1'h1, 8'h1c, 32'h001f_0109);
        trip[0] <= 1'h1;
        repeat (40) @(posedge pclk);
        trip[0] <= 1'h0;
        repeat (10) @(posedge pclk);
        check("glitch", 6'h3f, pin_oe_ff);
        for (c = 1; c < 4; c++) begin
            apb(1'h1, 8'h1c, 32'h001f_0009 | (c << 8));
            trip[0] <= 1'h1;
            n = 0;
            while (pin_oe_ff !== 6'h00 && n < 2200) begin
                @(posedge pclk);
                n++;
            end
            check("sampled", 1'h1, n >= 15 * divs[c] && n <= 16 * divs[c] + 12);
            trip[0] <= 1'h0;
            apb(1'h1, 8'h20, 32'h1);
        end
        standby <= 1'h1;
        repeat (6) @(posedge pclk);
        check("oe", 6'h00, pin_oe_ff);
        standby <= 1'h0;
        repeat (4) @(posedge pclk);
        rchk("dead", 8'h14, 32'hffff);
        rchk("carrier", 8'h18, 32'hffff);
        osc_stop <= 1'h1;
        repeat (6) @(posedge pclk);
        check("oe", 6'h00, pin_oe_ff);
        osc_stop <= 1'h0;
        results;
    end
endmodule
`default_nettype wire

// >>> hdl/tpo_shutdown_filter.v
// tpo_shutdown_filter: one shutdown input, synchronised, then falling edge
// or sixteen consecutive low samples at the selected prescaler rate.
// assumes smp_en is a one-cycle pulse from the top's divider.
`timescale 1ns/100ps
`default_nettype none
`include "tpo_map.vh"

module tpo_shutdown_filter (
    // clock and reset
    input wire pclk,
    input wire presetn,
    input wire soft_clr,
    // pin and configuration
    input wire pin_n,
    input wire [1:0] sel,
    input wire smp_en,
    // result
    output reg detect_ff
);

reg sync1_ff;
reg sync2_ff;
reg prev_ff;
reg [4:0] low_cnt_ff;
reg [4:0] nxt_low_cnt;
reg nxt_detect;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1_ff <= 1'b1;
        sync2_ff <= 1'b1;
        prev_ff <= 1'b1;
    end else begin
        sync1_ff <= pin_n;
        sync2_ff <= sync1_ff;
        prev_ff <= sync2_ff;
    end
end

always @* begin
    nxt_low_cnt = low_cnt_ff;
    nxt_detect = 1'b0;
    if (sel == 2'b00) begin
        nxt_detect = prev_ff & ~sync2_ff;
        nxt_low_cnt = 5'd0;
    end else if (smp_en) begin
        if (sync2_ff) begin
            nxt_low_cnt = 5'd0;
        end else if (low_cnt_ff == `TPO_SAMPLES - 5'd1) begin
            nxt_detect = 1'b1;
            nxt_low_cnt = 5'd0;
        end else begin
            nxt_low_cnt = low_cnt_ff + 5'd1;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_cnt_ff <= 5'd0;
        detect_ff <= 1'b0;
    end else if (soft_clr) begin
        low_cnt_ff <= 5'd0;
        detect_ff <= 1'b0;
    end else begin
        low_cnt_ff <= nxt_low_cnt;
        detect_ff <= nxt_detect;
    end
end

endmodule
`default_nettype wire

// >>> hdl/tpo_top.v
// tpo_top: channel mode registers, channel 3/4 complementary pwm core,
// dead time and carrier period, and the output-disable unit for six pins.
// assumes an apb master on pclk; pins and shutdown inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "tpo_map.vh"

module tpo_top #(
    parameter HAS_LEVEL_CHECK = 1
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // system
    input wire manual_resetn,
    input wire standby,
    input wire osc_stop,
    input wire [3:0] shutdown_inputs_n,
    // high-current pins: ch3 b, ch3 d, ch4 a, ch4 b, ch4 c, ch4 d
    output reg [5:0] pin_o_ff,
    output reg [5:0] pin_oe_ff,
    // interrupt request
    output reg irq_ff
);

// mode code legality per channel
function mode_ok;
    input [2:0] ch;
    input [3:0] md;
    begin
        case (md)
            `TPO_MD_NORMAL, `TPO_MD_PWM1: mode_ok = 1'b1;
            `TPO_MD_PWM2: mode_ok = (ch != 3'd3) && (ch != 3'd4);
            4'h4, 4'h5, 4'h6, 4'h7: mode_ok = (ch == 3'd1) || (ch == 3'd2);
            `TPO_MD_RSYNC, `TPO_MD_CP_PEAK, `TPO_MD_CP_VALLEY, `TPO_MD_CP_BOTH:
                mode_ok = (ch == 3'd3);
            default: mode_ok = 1'b0;
        endcase
    end
endfunction

function is_comp;
    input [3:0] md;
    begin
        is_comp = (md == `TPO_MD_CP_PEAK) || (md == `TPO_MD_CP_VALLEY) || (md == `TPO_MD_CP_BOTH);
    end
endfunction

// synchronisers for asynchronous level inputs
reg [2:0] sy1_ff;
reg [2:0] sy2_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sy1_ff <= 3'b001;
        sy2_ff <= 3'b001;
    end else begin
        sy1_ff <= {osc_stop, standby, manual_resetn};
        sy2_ff <= sy1_ff;
    end
end
wire mreset = ~sy2_ff[0];
wire stby = sy2_ff[1];
wire ostop = sy2_ff[2];

// registers
reg [4:0] mode_ff [0:4];
reg [15:0] dead_ff;
reg [15:0] carrier_ff;
reg [31:0] ctrl_ff;
reg [6:0] stat_ff;
reg [15:0] cmpa_ff;
reg [15:0] cmpc_ff;
reg [15:0] ch3_cnt_ff;
reg [15:0] ch4_cnt_ff;
reg [15:0] aux_cnt_ff;
reg aux_up_ff;
reg start_d_ff;

wire [3:0] md3 = mode_ff[3][3:0];
wire comp3 = is_comp(md3);
wire rsync3 = (md3 == `TPO_MD_RSYNC);
// channel 4 follows channel 3 in the paired modes
wire [4:0] mode4_eff = (comp3 || rsync3) ? mode_ff[3] : mode_ff[4];
wire buf_a3 = mode_ff[3][`TPO_BUF_BIT];

// apb decode
wire acc = psel & penable;
wire wr_go = acc & pready_ff & pwrite;
reg [31:0] rd_mux;
reg hit;
always @* begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `TPO_OFS_MODE0) begin
        rd_mux = {27'h0, mode_ff[0]};
    end else if (paddr == `TPO_OFS_MODE1) begin
        rd_mux = {27'h0, mode_ff[1]};
    end else if (paddr == `TPO_OFS_MODE2) begin
        rd_mux = {27'h0, mode_ff[2]};
    end else if (paddr == `TPO_OFS_MODE3) begin
        rd_mux = {27'h0, mode_ff[3]};
    end else if (paddr == `TPO_OFS_MODE4) begin
        rd_mux = {27'h0, mode_ff[4]};
    end else if (paddr == `TPO_OFS_DEAD) begin
        rd_mux = {16'h0, dead_ff};
    end else if (paddr == `TPO_OFS_CARRIER) begin
        rd_mux = {16'h0, carrier_ff};
    end else if (paddr == `TPO_OFS_CTRL) begin
        rd_mux = ctrl_ff;
    end else if (paddr == `TPO_OFS_STAT) begin
        rd_mux = {25'h0, stat_ff};
    end else if (paddr == `TPO_OFS_CMPA) begin
        rd_mux = {16'h0, cmpa_ff};
    end else if (paddr == `TPO_OFS_CMPC) begin
        rd_mux = {16'h0, cmpc_ff};
    end else if (paddr == `TPO_OFS_CNT) begin
        rd_mux = {aux_cnt_ff, ch3_cnt_ff};
    end else begin
        hit = 1'b0;
    end
end

// one wait state: answer in the second access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h0000_0000;
    end else begin
        pready_ff <= acc & ~pready_ff;
        pslverr_ff <= acc & ~pready_ff & ~hit;
        prdata_ff <= (acc & ~pready_ff & ~pwrite & hit) ? rd_mux : 32'h0000_0000;
    end
end

// mode registers, an illegal code for the channel keeps the old mode field; the buffer bit is still written, except on channels 1 and 2
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_mode
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_ff[gi] <= 5'h00;
            end else if (mreset) begin
                mode_ff[gi] <= 5'h00;
            end else if (wr_go && paddr == 8'h04 * gi) begin
                if (mode_ok(gi, pwdata[3:0])) begin
                    mode_ff[gi][3:0] <= pwdata[3:0];
                end
                if (gi != 1 && gi != 2) begin
                    mode_ff[gi][`TPO_BUF_BIT] <= pwdata[`TPO_BUF_BIT];
                end
            end
        end
    end
endgenerate

// dead time and carrier period survive manual reset
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dead_ff <= `TPO_DEAD_RST;
        carrier_ff <= `TPO_CARRIER_RST;
    end else if (stby) begin
        dead_ff <= `TPO_DEAD_RST;
        carrier_ff <= `TPO_CARRIER_RST;
    end else if (wr_go) begin
        if (paddr == `TPO_OFS_DEAD) begin
            dead_ff <= pwdata[15:0];
        end
        if (paddr == `TPO_OFS_CARRIER) begin
            carrier_ff <= pwdata[15:0];
        end
    end
end

// complementary pwm counters
wire start = ctrl_ff[`TPO_CTRL_START];
wire peak = aux_up_ff && (aux_cnt_ff == dead_ff);
wire valley = !aux_up_ff && (aux_cnt_ff == carrier_ff);
wire xfer = ((md3 == `TPO_MD_CP_PEAK) && peak) || ((md3 == `TPO_MD_CP_VALLEY) && valley)
    || ((md3 == `TPO_MD_CP_BOTH) && (peak || valley));
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ch3_cnt_ff <= 16'h0000;
        ch4_cnt_ff <= 16'h0000;
        aux_cnt_ff <= 16'h0000;
        aux_up_ff <= 1'b0;
        start_d_ff <= 1'b0;
    end else if (mreset) begin
        ch3_cnt_ff <= 16'h0000;
        ch4_cnt_ff <= 16'h0000;
        aux_cnt_ff <= 16'h0000;
        aux_up_ff <= 1'b0;
        start_d_ff <= 1'b0;
    end else begin
        start_d_ff <= start;
        if (!start) begin
            ch3_cnt_ff <= 16'h0000;
            ch4_cnt_ff <= 16'h0000;
            aux_cnt_ff <= 16'h0000;
            aux_up_ff <= 1'b0;
        end else if (!start_d_ff && comp3) begin
            ch3_cnt_ff <= dead_ff;
            ch4_cnt_ff <= 16'h0000;
            aux_cnt_ff <= dead_ff;
            aux_up_ff <= 1'b0;
        end else begin
            ch3_cnt_ff <= ch3_cnt_ff + 16'h0001;
            ch4_cnt_ff <= ch4_cnt_ff + 16'h0001;
            if (comp3 && valley) begin
                aux_up_ff <= 1'b1;
                aux_cnt_ff <= aux_cnt_ff + 16'h0001;
            end else if (peak) begin
                aux_up_ff <= 1'b0;
                aux_cnt_ff <= aux_cnt_ff - 16'h0001;
            end else if (aux_up_ff) begin
                aux_cnt_ff <= aux_cnt_ff + 16'h0001;
            end else begin
                aux_cnt_ff <= aux_cnt_ff - 16'h0001;
            end
        end
    end
end

// compare registers; C buffers A when buffer select is set
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cmpa_ff <= 16'hffff;
        cmpc_ff <= 16'hffff;
    end else if (mreset) begin
        cmpa_ff <= 16'hffff;
        cmpc_ff <= 16'hffff;
    end else begin
        if (wr_go && paddr == `TPO_OFS_CMPC) begin
            cmpc_ff <= pwdata[15:0];
        end
        if (wr_go && paddr == `TPO_OFS_CMPA && !(buf_a3 && comp3)) begin
            cmpa_ff <= pwdata[15:0];
        end else if (buf_a3 && (comp3 ? xfer : (ch3_cnt_ff == cmpa_ff))) begin
            cmpa_ff <= cmpc_ff;
        end
    end
end

// compare events
wire amask = comp3 && ctrl_ff[`TPO_CTRL_AMASK];
wire ev_a = start && (ch3_cnt_ff == cmpa_ff);
wire ev_c_any = (ch3_cnt_ff == cmpc_ff) || (ch4_cnt_ff == cmpc_ff) || (aux_cnt_ff == cmpc_ff);
wire ev_c = start && (amask ? ev_c_any
    : (!buf_a3 && ch3_cnt_ff == cmpc_ff));

// shutdown inputs
reg [6:0] pre_cnt_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pre_cnt_ff <= 7'h00;
    end else begin
        pre_cnt_ff <= pre_cnt_ff + 7'h01;
    end
end
wire [3:0] taps = {((pre_cnt_ff & `TPO_DIV128_MASK) == `TPO_DIV128_MASK),
    ((pre_cnt_ff & `TPO_DIV16_MASK) == `TPO_DIV16_MASK),
    ((pre_cnt_ff & `TPO_DIV8_MASK) == `TPO_DIV8_MASK), 1'b0};
wire [3:0] sd_det;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sd
        wire [1:0] sel = ctrl_ff[`TPO_CTRL_SEL_LO + 2 * gi +: 2];
        tpo_shutdown_filter u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .soft_clr(mreset),
            .pin_n(shutdown_inputs_n[gi]),
            .sel(sel),
            .smp_en(taps[sel]),
            .detect_ff(sd_det[gi])
        );
    end
endgenerate

// output level conflict: both pins of a pair driven low
wire [2:0] pair_low = {~pin_o_ff[3] & ~pin_o_ff[5], ~pin_o_ff[2] & ~pin_o_ff[4],
    ~pin_o_ff[0] & ~pin_o_ff[1]};
reg conflict_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        conflict_ff <= 1'b0;
    end else begin
        conflict_ff <= (HAS_LEVEL_CHECK != 0) && ctrl_ff[`TPO_CTRL_LVLEN]
            && (|(pair_low & {3{pin_oe_ff[0]}}));
    end
end

// control and sticky status, write one to clear, set wins
wire [6:0] stat_set = {ev_c, ev_a, conflict_ff, sd_det};
wire [6:0] stat_clr = (wr_go && paddr == `TPO_OFS_STAT) ? pwdata[6:0] : 7'h00;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_ff <= 32'h0000_0000;
        stat_ff <= 7'h00;
    end else if (mreset) begin
        ctrl_ff <= 32'h0000_0000;
        stat_ff <= 7'h00;
    end else begin
        if (wr_go && paddr == `TPO_OFS_CTRL) begin
            ctrl_ff <= pwdata & 32'h001f_ff0f;
        end
        stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end
end

// pin levels and enables
wire hiz = (|stat_ff[4:0]) || stby || ostop;
wire ph_u = aux_cnt_ff < cmpa_ff;
wire ph_v = ch3_cnt_ff < cmpa_ff;
wire ph_w = ch4_cnt_ff < cmpa_ff;
wire drive = ctrl_ff[`TPO_CTRL_OEN] && start && (comp3 || rsync3 || mode4_eff[3:0] != `TPO_MD_NORMAL);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_o_ff <= 6'h3f;
        pin_oe_ff <= 6'h00;
        irq_ff <= 1'b0;
    end else begin
        pin_o_ff <= {~ph_w, ~ph_v, ph_w, ph_v, ~ph_u, ph_u};
        pin_oe_ff <= (drive && !hiz) ? 6'h3f : 6'h00;
        irq_ff <= |(stat_ff[4:0] & ctrl_ff[`TPO_CTRL_IE_LO +: 5]);
    end
end

endmodule
`default_nettype wire

// >>> include/tpo_map.vh
// tpo_map.vh: register offsets, field positions, reset values and timing counts
// for the timer mode, complementary pwm and output-disable block.
// assumes a 32-bit apb slave at 100 MHz; byte addresses below.
//
// Contract
// - buffer select 0 normal, 1 C buffers A
// - buffer select bit 4; buffered C no events
// - channels 1, 2 buffer bit reads zero
// - mode field bits 3..0 select operation
// - codes 1101/1110/1111 complementary pwm transfer points
// - pwm2 not ch3/4; phase not ch0/3/4
// - sync/complementary only ch3; ch4 follows ch3
// - restart loads dead time into ch3 counter
// - dead time all ones on reset, standby
// - carrier match turns aux counter upward
// - carrier period all ones, manual reset keeps
// - a-mask: buffer flags only from three counters
// - shutdown input edge or 16 low samples
// - shutdown detection forces six pins high impedance
// - simultaneous low outputs force high impedance
// - sampling and comparison results raise interrupts; irq here only from status bits 4..0, not cmp a/c
// - oscillator stop or standby forces high impedance
`ifndef TPO_MAP_VH
`define TPO_MAP_VH

// register byte offsets
`define TPO_OFS_MODE0 8'h00
`define TPO_OFS_MODE1 8'h04
`define TPO_OFS_MODE2 8'h08
`define TPO_OFS_MODE3 8'h0c
`define TPO_OFS_MODE4 8'h10
`define TPO_OFS_DEAD 8'h14
`define TPO_OFS_CARRIER 8'h18
`define TPO_OFS_CTRL 8'h1c
`define TPO_OFS_STAT 8'h20
`define TPO_OFS_CMPA 8'h24
`define TPO_OFS_CMPC 8'h28
`define TPO_OFS_CNT 8'h2c

// mode register fields
`define TPO_BUF_BIT 4
// control register fields
`define TPO_CTRL_START 0
`define TPO_CTRL_AMASK 1
`define TPO_CTRL_LVLEN 2
`define TPO_CTRL_OEN 3
`define TPO_CTRL_SEL_LO 8
`define TPO_CTRL_IE_LO 16
// status register: bits 3..0 shutdown inputs, 4 level conflict, 5 cmp a, 6 cmp c

// reset values
`define TPO_DEAD_RST 16'hffff
`define TPO_CARRIER_RST 16'hffff

// mode codes
`define TPO_MD_NORMAL 4'h0
`define TPO_MD_PWM1 4'h2
`define TPO_MD_PWM2 4'h3
`define TPO_MD_RSYNC 4'h8
`define TPO_MD_CP_PEAK 4'hd
`define TPO_MD_CP_VALLEY 4'he
`define TPO_MD_CP_BOTH 4'hf

// low-level sampling: samples per detection and prescaler taps
`define TPO_SAMPLES 5'd16
`define TPO_DIV8_MASK 7'h07
`define TPO_DIV16_MASK 7'h0f
`define TPO_DIV128_MASK 7'h7f

`endif
